// File: common/dbtt_pkg.sv
// Package of the dither and bank timing trim register group.
// Assumes a 32-bit AXI4-Lite slave port with a 12-bit byte address.
package dbtt_pkg;

  // Register data width and count
  localparam int unsigned DATA_W = 8;
  localparam int unsigned NUM_REGS = 6;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned IDX_W = 10;

  // Register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_DITHER_CONTROL = 10'h09D;
  localparam logic [IDX_W-1:0] IDX_BANK0_ZERO_PHASE_TIMING = 10'h102;
  localparam logic [IDX_W-1:0] IDX_BANK0_QUADRATURE_TIMING = 10'h103;
  localparam logic [IDX_W-1:0] IDX_BANK1_ZERO_PHASE_TIMING = 10'h112;
  localparam logic [IDX_W-1:0] IDX_BANK1_QUADRATURE_TIMING = 10'h113;
  localparam logic [IDX_W-1:0] IDX_BANK4_ZERO_PHASE_TIMING = 10'h142;

  // Slot numbers of the registers inside the word array
  localparam int unsigned SLOT_DITHER = 0;
  localparam int unsigned SLOT_B0_ZERO = 1;
  localparam int unsigned SLOT_B0_QUAD = 2;
  localparam int unsigned SLOT_B1_ZERO = 3;
  localparam int unsigned SLOT_B1_QUAD = 4;
  localparam int unsigned SLOT_B4_ZERO = 5;

  // Index of each slot, in slot order
  localparam logic [NUM_REGS-1:0][IDX_W-1:0] SLOT_IDX = {
    IDX_BANK4_ZERO_PHASE_TIMING, IDX_BANK1_QUADRATURE_TIMING, IDX_BANK1_ZERO_PHASE_TIMING,
    IDX_BANK0_QUADRATURE_TIMING, IDX_BANK0_ZERO_PHASE_TIMING, IDX_DITHER_CONTROL};

  // Reset values, in slot order
  localparam logic [DATA_W-1:0] RST_DITHER_CONTROL = 8'h01;
  localparam logic [DATA_W-1:0] RST_TIMING = 8'h00;
  localparam logic [NUM_REGS-1:0][DATA_W-1:0] SLOT_RST = {
    RST_TIMING, RST_TIMING, RST_TIMING, RST_TIMING, RST_TIMING, RST_DITHER_CONTROL};

  // Dither control field positions
  localparam int unsigned DITHER_ENABLE_BIT = 0;
  localparam int unsigned DITHER_AMPLITUDE_SELECT_BIT = 1;
  localparam int unsigned ROUNDING_ERROR_SELECT_BIT = 2;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Sequencer states
  typedef enum logic [0:0] {
    DBTT_ST_LOAD = 1'b0,
    DBTT_ST_RUN = 1'b1
  } dbtt_state_e_t;

  // Factory fuse contents, one word per slot
  typedef struct packed {
    logic [NUM_REGS-1:0][DATA_W-1:0] word;
  } dbtt_fuse_t;

  // Settings handed to the converter
  typedef struct packed {
    logic dither_enable;
    logic dither_amplitude_select;
    logic rounding_error_offset;
    logic rounding_error_quarter;
    logic [DATA_W-1:0] bank0_applied_word;
    logic [DATA_W-1:0] bank1_applied_word;
    logic [DATA_W-1:0] bank4_zero_phase_word;
  } dbtt_trim_t;

  // State of the register group, apart from the stored words
  typedef struct packed {
    dbtt_state_e_t st;
    logic awready;
    logic aw_held;
    logic [IDX_W-1:0] aw_idx;
    logic wready;
    logic w_held;
    logic [DATA_W-1:0] w_data;
    logic w_lane0;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [DATA_W-1:0] rdata;
    logic [1:0] rresp;
    dbtt_trim_t trim;
  } dbtt_state_t;

endpackage

// File: rtl/dbtt_word.sv
// One fuse-backed read/write register word.
// Assumes a single clock with synchronous active-low reset.
`timescale 1ns/10ps
`default_nettype none
module dbtt_word #(
  parameter int unsigned W = 8,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Fuse load
  input wire logic load_en,
  input wire logic [W-1:0] fuse_val,
  // Software write
  input wire logic wr_en,
  input wire logic [W-1:0] wr_data,
  // Stored value
  output logic [W-1:0] q
);

  logic [W-1:0] q_r;
  logic [W-1:0] q_nxt;

  // Fuse copy after reset, then software writes
  always_comb begin
    q_nxt = q_r;
    if (load_en) begin
      q_nxt = fuse_val;
    end else if (wr_en) begin
      q_nxt = wr_data;
    end
  end

  // Constant under reset, fuse value loaded after release
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      q_r <= RST_VAL;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign q = q_r;

endmodule
`default_nettype wire

// File: rtl/dbtt_regs.sv
// Dither control and bank sampling-time trim registers with an AXI4-Lite slave.
// Assumes fuse contents are stable at reset release and the mode input is synchronous.
//
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/10ps
`default_nettype none
module dbtt_regs (
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic RST_N,
  // Factory fuse contents
  input wire dbtt_pkg::dbtt_fuse_t FUSE,
  // Converter channel mode, one for single channel
  input wire logic SINGLE_CHANNEL,
  // AXI4-Lite write address
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [dbtt_pkg::ADDR_W-1:0] S_AXI_AWADDR,
  input wire logic [2:0] S_AXI_AWPROT,
  // AXI4-Lite write data
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  // AXI4-Lite write response
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  output logic [1:0] S_AXI_BRESP,
  // AXI4-Lite read address
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  input wire logic [dbtt_pkg::ADDR_W-1:0] S_AXI_ARADDR,
  input wire logic [2:0] S_AXI_ARPROT,
  // AXI4-Lite read data
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  // Settings to the converter
  output dbtt_pkg::dbtt_trim_t TRIM
);

  dbtt_pkg::dbtt_state_t s_r;
  dbtt_pkg::dbtt_state_t s_nxt;

  // Stored words, one per slot
  logic [dbtt_pkg::NUM_REGS-1:0][dbtt_pkg::DATA_W-1:0] word_q;
  logic [dbtt_pkg::NUM_REGS-1:0] word_wr;
  logic load_en;

  // Decode helpers
  logic aw_take;
  logic w_take;
  logic ar_take;
  logic do_write;
  logic [dbtt_pkg::NUM_REGS-1:0] aw_hit;
  logic [dbtt_pkg::NUM_REGS-1:0] ar_hit;
  logic [dbtt_pkg::IDX_W-1:0] ar_idx;
  logic [dbtt_pkg::DATA_W-1:0] rd_word;
  logic [dbtt_pkg::DATA_W-1:0] dither_word;

  // Protection bits carry no meaning here
  logic unused_prot;
  assign unused_prot = ^{S_AXI_AWPROT, S_AXI_ARPROT, S_AXI_WDATA[31:8], S_AXI_WSTRB[3:1]};

  // Handshakes on the registered ready signals
  assign aw_take = S_AXI_AWVALID && s_r.awready;
  assign w_take = S_AXI_WVALID && s_r.wready;
  assign ar_take = S_AXI_ARVALID && s_r.arready;
  assign ar_idx = S_AXI_ARADDR[dbtt_pkg::ADDR_W-1:2];

  // Write fires once both halves are held and the response is free
  assign do_write = s_r.aw_held && s_r.w_held && !s_r.bvalid;

  // Fuse copy in the first cycle after reset release
  assign load_en = (s_r.st == dbtt_pkg::DBTT_ST_LOAD);

  // Address compare per slot
  always_comb begin
    for (int i = 0; i < dbtt_pkg::NUM_REGS; i++) begin
      aw_hit[i] = (s_r.aw_idx == dbtt_pkg::SLOT_IDX[i]);
      ar_hit[i] = (ar_idx == dbtt_pkg::SLOT_IDX[i]);
    end
  end

  // Write strobes only on lane 0, where the 8-bit word sits
  always_comb begin
    for (int i = 0; i < dbtt_pkg::NUM_REGS; i++) begin
      word_wr[i] = do_write && aw_hit[i] && s_r.w_lane0;
    end
  end

  // One fuse-backed word per register
  for (genvar g = 0; g < dbtt_pkg::NUM_REGS; g++) begin : g_word
    dbtt_word #(
      .W(dbtt_pkg::DATA_W),
      .RST_VAL(dbtt_pkg::SLOT_RST[g])
    ) u_word (
      .clk(REF_CLK),
      .rst_n(RST_N),
      .load_en(load_en),
      .fuse_val(FUSE.word[g]),
      .wr_en(word_wr[g]),
      .wr_data(s_r.w_data),
      .q(word_q[g])
    );
  end

  // Read mux; unmapped addresses read zero
  always_comb begin
    rd_word = '0;
    for (int i = 0; i < dbtt_pkg::NUM_REGS; i++) begin
      if (ar_hit[i]) begin
        rd_word = word_q[i];
      end
    end
  end

  assign dither_word = word_q[dbtt_pkg::SLOT_DITHER];

  // Next state of the whole group
  always_comb begin
    s_nxt = s_r;

    // Sequencer: one load cycle, then normal operation
    case (s_r.st)
      dbtt_pkg::DBTT_ST_LOAD: begin
        s_nxt.st = dbtt_pkg::DBTT_ST_RUN;
      end
      dbtt_pkg::DBTT_ST_RUN: begin
        s_nxt.st = dbtt_pkg::DBTT_ST_RUN;
      end
      default: begin
        s_nxt.st = dbtt_pkg::DBTT_ST_LOAD;
      end
    endcase

    // Capture write address
    if (aw_take) begin
      s_nxt.aw_held = 1'b1;
      s_nxt.aw_idx = S_AXI_AWADDR[dbtt_pkg::ADDR_W-1:2];
    end

    // Capture write data
    if (w_take) begin
      s_nxt.w_held = 1'b1;
      s_nxt.w_data = S_AXI_WDATA[dbtt_pkg::DATA_W-1:0];
      s_nxt.w_lane0 = S_AXI_WSTRB[0];
    end

    // Retire a finished write response
    if (s_r.bvalid && S_AXI_BREADY) begin
      s_nxt.bvalid = 1'b0;
    end

    // Perform the write and raise the response
    if (do_write) begin
      s_nxt.aw_held = 1'b0;
      s_nxt.w_held = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = (|aw_hit) ? dbtt_pkg::RESP_OKAY : dbtt_pkg::RESP_SLVERR;
    end

    // Retire a finished read
    if (s_r.rvalid && S_AXI_RREADY) begin
      s_nxt.rvalid = 1'b0;
    end

    // Take a read and present its data next cycle
    if (ar_take) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rdata = rd_word;
      s_nxt.rresp = (|ar_hit) ? dbtt_pkg::RESP_OKAY : dbtt_pkg::RESP_SLVERR;
    end

    // Ready only in normal operation and with a free slot
    s_nxt.awready = (s_nxt.st == dbtt_pkg::DBTT_ST_RUN) && !s_nxt.aw_held;
    s_nxt.wready = (s_nxt.st == dbtt_pkg::DBTT_ST_RUN) && !s_nxt.w_held;
    s_nxt.arready = (s_nxt.st == dbtt_pkg::DBTT_ST_RUN) && !s_nxt.rvalid;

    // Dither settings from the stored control word
    s_nxt.trim.dither_enable = dither_word[dbtt_pkg::DITHER_ENABLE_BIT];
    s_nxt.trim.dither_amplitude_select = dither_word[dbtt_pkg::DITHER_AMPLITUDE_SELECT_BIT];
    s_nxt.trim.rounding_error_offset = dither_word[dbtt_pkg::ROUNDING_ERROR_SELECT_BIT];
    // Quarter-rate spur effect only in single channel mode
    s_nxt.trim.rounding_error_quarter =
      dither_word[dbtt_pkg::ROUNDING_ERROR_SELECT_BIT] && SINGLE_CHANNEL;

    // Bank 0 word follows the clock phase of converter A
    if (SINGLE_CHANNEL) begin
      s_nxt.trim.bank0_applied_word = word_q[dbtt_pkg::SLOT_B0_QUAD];
    end else begin
      s_nxt.trim.bank0_applied_word = word_q[dbtt_pkg::SLOT_B0_ZERO];
    end

    // Bank 1 word follows the clock phase of converter A
    if (SINGLE_CHANNEL) begin
      s_nxt.trim.bank1_applied_word = word_q[dbtt_pkg::SLOT_B1_QUAD];
    end else begin
      s_nxt.trim.bank1_applied_word = word_q[dbtt_pkg::SLOT_B1_ZERO];
    end

    // Bank 4 word passes on in both modes
    s_nxt.trim.bank4_zero_phase_word = word_q[dbtt_pkg::SLOT_B4_ZERO];
  end

  // State register; all constants under reset
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      s_r.st <= dbtt_pkg::DBTT_ST_LOAD;
      s_r.awready <= 1'b0;
      s_r.aw_held <= 1'b0;
      s_r.aw_idx <= '0;
      s_r.wready <= 1'b0;
      s_r.w_held <= 1'b0;
      s_r.w_data <= '0;
      s_r.w_lane0 <= 1'b0;
      s_r.bvalid <= 1'b0;
      s_r.bresp <= dbtt_pkg::RESP_OKAY;
      s_r.arready <= 1'b0;
      s_r.rvalid <= 1'b0;
      s_r.rdata <= '0;
      s_r.rresp <= dbtt_pkg::RESP_OKAY;
      s_r.trim <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs straight from the state register
  assign S_AXI_AWREADY = s_r.awready;
  assign S_AXI_WREADY = s_r.wready;
  assign S_AXI_BVALID = s_r.bvalid;
  assign S_AXI_BRESP = s_r.bresp;
  assign S_AXI_ARREADY = s_r.arready;
  assign S_AXI_RVALID = s_r.rvalid;
  assign S_AXI_RDATA = {24'h000000, s_r.rdata};
  assign S_AXI_RRESP = s_r.rresp;
  assign TRIM = s_r.trim;

endmodule
`default_nettype wire

// File: verif/dbtt_regs_sva.sv
// Checker of the dither and bank timing trim register group.
// Assumes it is bound to dbtt_regs and sees only its ports.
`timescale 1ns/10ps
`default_nettype none
module dbtt_regs_sva (
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic RST_N,
  // Fuse and mode
  input wire dbtt_pkg::dbtt_fuse_t FUSE,
  input wire logic SINGLE_CHANNEL,
  // Write side
  input wire logic S_AXI_AWVALID,
  input wire logic S_AXI_AWREADY,
  input wire logic [dbtt_pkg::ADDR_W-1:0] S_AXI_AWADDR,
  input wire logic S_AXI_WVALID,
  input wire logic S_AXI_WREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  // Read side
  input wire logic S_AXI_ARVALID,
  input wire logic S_AXI_ARREADY,
  input wire logic S_AXI_RVALID,
  input wire logic [31:0] S_AXI_RDATA,
  // Settings
  input wire dbtt_pkg::dbtt_trim_t TRIM
);
  logic wr_any;
  logic [9:0] wr_idx;
  // Storing write taken with both channels at once
  assign wr_any = S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY && S_AXI_WSTRB[0];
  assign wr_idx = S_AXI_AWADDR[11:2];
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);
  // Dither fields seen three edges after the write is taken: store, settings, sample
  a_dith_enable: assert property (wr_any && wr_idx == dbtt_pkg::IDX_DITHER_CONTROL |-> ##3
    TRIM.dither_enable == $past(S_AXI_WDATA[0], 3)) else $error("dither enable mismatch");
  a_dith_amp: assert property (wr_any && wr_idx == dbtt_pkg::IDX_DITHER_CONTROL |-> ##3
    TRIM.dither_amplitude_select == $past(S_AXI_WDATA[1], 3)) else $error("amplitude mismatch");
  a_round_err: assert property (wr_any && wr_idx == dbtt_pkg::IDX_DITHER_CONTROL |-> ##3
    TRIM.rounding_error_offset == $past(S_AXI_WDATA[2], 3)) else $error("rounding select mismatch");
  a_quarter_single: assert property (TRIM.rounding_error_quarter ==
    (TRIM.rounding_error_offset && $past(SINGLE_CHANNEL))) else $error("quarter spur outside single mode");
  // Applied bank words after a write, mode held
  a_b0_zero: assert property (wr_any && wr_idx == dbtt_pkg::IDX_BANK0_ZERO_PHASE_TIMING ##2 !SINGLE_CHANNEL
    |-> ##1 TRIM.bank0_applied_word == $past(S_AXI_WDATA[7:0], 3)) else $error("bank0 zero word");
  a_b0_quad: assert property (wr_any && wr_idx == dbtt_pkg::IDX_BANK0_QUADRATURE_TIMING ##2 SINGLE_CHANNEL
    |-> ##1 TRIM.bank0_applied_word == $past(S_AXI_WDATA[7:0], 3)) else $error("bank0 quad word");
  a_b1_zero: assert property (wr_any && wr_idx == dbtt_pkg::IDX_BANK1_ZERO_PHASE_TIMING ##2 !SINGLE_CHANNEL
    |-> ##1 TRIM.bank1_applied_word == $past(S_AXI_WDATA[7:0], 3)) else $error("bank1 zero word");
  a_b1_quad: assert property (wr_any && wr_idx == dbtt_pkg::IDX_BANK1_QUADRATURE_TIMING ##2 SINGLE_CHANNEL
    |-> ##1 TRIM.bank1_applied_word == $past(S_AXI_WDATA[7:0], 3)) else $error("bank1 quad word");
  // Load edge first, settings follow one edge later, sampled on the next
  a_fuse_load: assert property (!$past(RST_N) |-> ##2 (TRIM.bank4_zero_phase_word == FUSE.word[5]
    && TRIM.dither_enable == FUSE.word[0][0])) else $error("fuse value not loaded");
  a_read_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID
    && S_AXI_RDATA[31:8] == 24'h000000) else $error("read answer late or wide");
endmodule
bind dbtt_regs dbtt_regs_sva i_sva (
  .REF_CLK(REF_CLK),
  .RST_N(RST_N),
  .FUSE(FUSE),
  .SINGLE_CHANNEL(SINGLE_CHANNEL),
  .S_AXI_AWVALID(S_AXI_AWVALID),
  .S_AXI_AWREADY(S_AXI_AWREADY),
  .S_AXI_AWADDR(S_AXI_AWADDR),
  .S_AXI_WVALID(S_AXI_WVALID),
  .S_AXI_WREADY(S_AXI_WREADY),
  .S_AXI_WDATA(S_AXI_WDATA),
  .S_AXI_WSTRB(S_AXI_WSTRB),
  .S_AXI_ARVALID(S_AXI_ARVALID),
  .S_AXI_ARREADY(S_AXI_ARREADY),
  .S_AXI_RVALID(S_AXI_RVALID),
  .S_AXI_RDATA(S_AXI_RDATA),
  .TRIM(TRIM)
);
`default_nettype wire

// File: verif/dbtt_regs_bench.sv
// Testbench of the dither and bank timing trim register group.
// Assumes the checker is bound; the bench drives every port itself.
`timescale 1ns/10ps
`default_nettype none
module dbtt_regs_bench;
  logic ref_clk, rst_n, single_ch, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, got;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, resp;
  logic [7:0] val [6];
  dbtt_pkg::dbtt_fuse_t fuse;
  dbtt_pkg::dbtt_trim_t trim, tq;
  int n_mismatch, samples_checked;
  dbtt_regs i_dut (.REF_CLK(ref_clk), .RST_N(rst_n), .FUSE(fuse), .SINGLE_CHANNEL(single_ch),
    .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_AWADDR(awaddr), .S_AXI_AWPROT(3'h0),
    .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb),
    .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_BRESP(bresp), .S_AXI_ARVALID(arvalid),
    .S_AXI_ARREADY(arready), .S_AXI_ARADDR(araddr), .S_AXI_ARPROT(3'h0), .S_AXI_RVALID(rvalid),
    .S_AXI_RREADY(rready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .TRIM(trim));
  // Verdict and end of run
  task automatic final_report();
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Comparisons
  task automatic chk_word(input string name, input logic [31:0] exp, input logic [31:0] seen);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic chk_resp(input string name, input logic [1:0] exp, input logic [1:0] seen);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // Bound on every wait
  task automatic guard(inout int n);
    n++;
    if (n > 50) begin
      n_mismatch++;
      final_report();
    end
  endtask
  // Byte address of a slot
  function automatic logic [11:0] addr(input int i);
    return {dbtt_pkg::SLOT_IDX[i], 2'b00};
  endfunction
  // Write: both channels offered, each released when taken, then response
  task automatic axi_write(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    logic ta, tw, aw_done, w_done;
    int n;
    {aw_done, w_done, ta, n} = '0;
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= d;
    wstrb <= s;
    bready <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(negedge ref_clk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      @(posedge ref_clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      aw_done |= ta;
      w_done |= tw;
      guard(n);
    end
    ta = 1'b0;
    while (!ta) begin
      @(negedge ref_clk);
      ta = bvalid;
      resp = bresp;
      @(posedge ref_clk);
      guard(n);
    end
    bready <= 1'b0;
    // Let an edge pass so a following call does not drive bready twice at once
    @(posedge ref_clk);
  endtask
  // Read: address, then data and response
  task automatic axi_read(input logic [11:0] a);
    logic ta;
    int n;
    {ta, n} = '0;
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    while (!ta) begin
      @(negedge ref_clk);
      ta = arready;
      @(posedge ref_clk);
      guard(n);
    end
    arvalid <= 1'b0;
    ta = 1'b0;
    while (!ta) begin
      @(negedge ref_clk);
      ta = rvalid;
      got = rdata;
      resp = rresp;
      @(posedge ref_clk);
      guard(n);
    end
    rready <= 1'b0;
    // Let an edge pass so a following call does not drive rready twice at once
    @(posedge ref_clk);
  endtask
  // Reset pulse, then settings captured once settled
  task automatic do_reset();
    rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
  endtask
  task automatic trim_wait();
    repeat (3) @(posedge ref_clk);
    @(negedge ref_clk);
    tq = trim;
    @(posedge ref_clk);
  endtask
  // Clock
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // Main sequence
  initial begin
    rst_n = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready, single_ch, n_mismatch, samples_checked} = '0;
    {awaddr, araddr, wdata, wstrb} = '0;
    for (int i = 0; i < 6; i++) val[i] = 8'h16 + 8'(i * 17);
    for (int i = 0; i < 6; i++) fuse.word[i] = val[i];
    do_reset();
    trim_wait();
    chk_word("fuse_dither_enable", 32'(val[0][0]), 32'(tq.dither_enable));
    chk_word("fuse_bank4_word", 32'(val[5]), 32'(tq.bank4_zero_phase_word));
    for (int i = 0; i < 6; i++) begin
      axi_read(addr(i));
      chk_word("fuse_readback", 32'(val[i]), got);
      val[i] = ~val[i];
      single_ch <= (i % 2 == 0) && (i > 0);
      axi_write(addr(i), {24'hFFFFFF, val[i]}, 4'hF);
      chk_resp("write_resp", dbtt_pkg::RESP_OKAY, resp);
    end
    for (int i = 0; i < 6; i++) begin
      axi_read(addr(i));
      chk_word("written_readback", 32'(val[i]), got);
    end
    // Every dither setting in both channel modes
    for (int v = 0; v < 16; v++) begin
      single_ch <= v[3];
      axi_write(addr(0), 32'(v[2:0]), 4'h1);
      trim_wait();
      chk_word("dither_enable", 32'(v[0]), 32'(tq.dither_enable));
      chk_word("amplitude_select", 32'(v[1]), 32'(tq.dither_amplitude_select));
      chk_word("rounding_offset", 32'(v[2]), 32'(tq.rounding_error_offset));
      chk_word("rounding_quarter", 32'(v[2] & v[3]), 32'(tq.rounding_error_quarter));
    end
    // Applied bank words per mode
    single_ch <= 1'b0;
    trim_wait();
    chk_word("bank0_dual", 32'(val[1]), 32'(tq.bank0_applied_word));
    chk_word("bank1_dual", 32'(val[3]), 32'(tq.bank1_applied_word));
    single_ch <= 1'b1;
    trim_wait();
    chk_word("bank0_single", 32'(val[2]), 32'(tq.bank0_applied_word));
    chk_word("bank1_single", 32'(val[4]), 32'(tq.bank1_applied_word));
    chk_word("bank4_written", 32'(val[5]), 32'(tq.bank4_zero_phase_word));
    // Unmapped place and empty strobe
    axi_write(12'h000, 32'h000000FF, 4'hF);
    chk_resp("unmapped_write", dbtt_pkg::RESP_SLVERR, resp);
    axi_read(12'h000);
    chk_resp("unmapped_read", dbtt_pkg::RESP_SLVERR, resp);
    chk_word("unmapped_data", 32'h00000000, got);
    axi_write(addr(5), 32'h00000077, 4'h0);
    chk_resp("no_strobe_write", dbtt_pkg::RESP_OKAY, resp);
    axi_read(addr(5));
    chk_word("no_strobe_readback", 32'(val[5]), got);
    // Second reset reloads fuses over written values
    fuse.word[0] <= 8'h01;
    do_reset();
    axi_read(addr(0));
    chk_word("reload_dither", 32'h00000001, got);
    axi_read(addr(3));
    chk_word("reload_bank1", 32'(8'h16 + 8'(51)), got);
    final_report();
  end
endmodule
`default_nettype wire
